// file: hw/drive_status_params.svh
// Constants for the drive condition word, reference scaling and protocol setup.
// Assumes inclusion by bare name from the package and the design modules.
// Function
// [RL1] Bit 00 clear on trip, else ready
// [RL2] Bit 01 ready with coast requested
// [RL3] Bit 02 set when start would run
// [RL4] Bit 03 set while tripped awaiting reset
// [RL5] Bits 04, 05, 12 always zero
// [RL6] Bit 06 follows trip lock
// [RL7] Bit 07 follows any warning
// [RL8] Bit 08 set when speed equals reference
// [RL9] Bit 09 and serial control gated locally
// [RL10] Bit 10 set inside frequency limits
// [RL11] Bit 11 set on start or frequency
// [RL12] Bit 13 on DC link out of window
// [RL13] Bit 14 over ceiling, trip after delay
// [RL14] Bit 15 on any temperature limit
// [RL15] Reference 0..16384 maps onto min..max span
// [RL16] Reference signed, up to +-32767
// [RL17] Negative reference reverses rotation
// [RL18] Frequency word 16384 is full span
// [RL19] Frequency word signed within +-32767
// [RL20] Two-bit protocol select, default native
// [RL21] Address ranges per protocol, default 1
// [RL22] Status word sampled on one edge
`ifndef DRIVE_STATUS_PARAMS_SVH
`define DRIVE_STATUS_PARAMS_SVH

// Status word bit positions
`define BIT_CONTROL_READY 0
`define BIT_DRIVE_READY 1
`define BIT_STANDBY 2
`define BIT_TRIPPED 3
`define BIT_TRIP_LOCK 6
`define BIT_WARNING 7
`define BIT_AT_REFERENCE 8
`define BIT_SERIAL_CONTROL 9
`define BIT_IN_RANGE 10
`define BIT_RUNNING 11
`define BIT_VOLTAGE 13
`define BIT_CURRENT 14
`define BIT_THERMAL 15

// Scaling: 16384 is 100 percent, 32767 the signed ceiling
`define SCALE_SHIFT 14
`define WORD_MAX 16'h7fff

// Protocol codes
`define PROTO_NATIVE 2'h0
`define PROTO_AUTOMATION_A 2'h1
`define PROTO_AUTOMATION_B 2'h2
`define PROTO_MODBUS 2'h3

// Address ranges per protocol
`define ADDR_NATIVE_MIN 8'h00
`define ADDR_NATIVE_MAX 8'h7e
`define ADDR_A_MIN 8'h01
`define ADDR_A_MAX 8'hff
`define ADDR_B_MIN 8'h00
`define ADDR_B_MAX 8'h62
`define ADDR_MODBUS_MIN 8'h01
`define ADDR_MODBUS_MAX 8'hf7

// Reset values
`define RESET_PROTOCOL 2'h0
`define RESET_ADDRESS 8'h01
`define RESET_WORD 16'h0000

// Divider length in cycles
`define DIV_STEPS 6'h20

`endif

// file: hw/drive_status_pkg.sv
// Types shared by the status word block and its divider.
// Assumes the params header sits beside it.
`include "drive_status_params.svh"

package drive_status_pkg;

  typedef enum logic {div_idle, div_run} div_phase_t;

  typedef struct packed {
    div_phase_t phase;
    logic [5:0] count;
    logic [16:0] rem;
    logic [31:0] quo;
    logic [15:0] dsr;
    logic done;
  } div_state_t;

  typedef struct packed {
    logic [2:0] coast_sync;
    logic coast_level;
    logic [15:0] status;
    logic [15:0] speed_demand;
    logic reverse;
    logic [1:0] protocol;
    logic [7:0] address;
    logic address_error;
    logic [23:0] oc_count;
    logic oc_trip;
    logic [15:0] freq_word;
    logic div_start;
  } top_state_t;

endpackage

// file: hw/div_if.sv
// Carrier between the status block and its unsigned divider.
// Assumes one clock shared by both ends.
`timescale 1ns/10ps

interface div_if;
  logic start;
  logic [31:0] dividend;
  logic [15:0] divisor;
  logic busy;
  logic done;
  logic [31:0] quotient;

  modport requester (output start, output dividend, output divisor, input busy, input done, input quotient);
  modport engine (input start, input dividend, input divisor, output busy, output done, output quotient);
endinterface

// file: hw/serial_divider.sv
// Restoring divider, one quotient bit per clock, 32 by 16 bits.
// Assumes start is only raised while busy is low.
`timescale 1ns/10ps
`include "drive_status_params.svh"

module serial_divider
  import drive_status_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  div_if.engine div
);

  div_state_t s;
  div_state_t next_s;
  logic [16:0] shifted;

  // One restoring step per cycle; zero divisor gives all ones, clamped later
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    shifted = {s.rem[15:0], s.quo[31]};
    case (s.phase)
      div_idle: begin
        if (div.start) begin
          next_s.phase = div_run;
          next_s.count = `DIV_STEPS;
          next_s.rem = 17'h00000;
          next_s.quo = div.dividend;
          next_s.dsr = div.divisor;
        end
      end
      div_run: begin
        if (shifted >= {1'b0, s.dsr}) begin
          next_s.rem = shifted - {1'b0, s.dsr};
          next_s.quo = {s.quo[30:0], 1'b1};
        end else begin
          next_s.rem = shifted;
          next_s.quo = {s.quo[30:0], 1'b0};
        end
        next_s.count = s.count - 6'h01;
        if (s.count == 6'h01) begin
          next_s.phase = div_idle;
          next_s.done = 1'b1;
        end
      end
      default: next_s.phase = div_idle;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign div.busy = (s.phase == div_run);
  assign div.done = s.done;
  assign div.quotient = s.quo;

endmodule // serial_divider

// file: hw/drive_status_words.sv
// Drive condition word, speed setpoint scaling, output frequency word and protocol setup.
// Assumes condition flags come from logic on clk; only the coast terminal is a pin.
`timescale 1ns/10ps
`include "drive_status_params.svh"

module drive_status_words
  import drive_status_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  // Condition flags from the drive
  input wire logic tripped,
  input wire logic trip_lock,
  input wire logic trip_clear,
  input wire logic drive_ready,
  input wire logic coast_terminal_pin,
  input wire logic serial_coast_cmd,
  input wire logic start_cmd,
  input wire logic warning_any,
  input wire logic keypad_stop,
  input wire logic hand_mode,
  input wire logic dc_link_low,
  input wire logic dc_link_high,
  input wire logic motor_hot,
  input wire logic drive_hot,
  input wire logic thermistor_hot,
  input wire logic [15:0] output_current,
  input wire logic [15:0] output_current_ceiling,
  input wire logic [23:0] overcurrent_delay_cycles,
  input wire logic [15:0] motor_speed,
  input wire logic [15:0] output_frequency,
  input wire logic output_reversed,
  input wire logic [15:0] freq_low_limit,
  input wire logic [15:0] freq_high_limit,
  input wire logic [15:0] ref_min,
  input wire logic [15:0] ref_max,
  // Serial side words
  input wire logic setpoint_write,
  input wire logic [15:0] speed_setpoint_word,
  output logic [15:0] drive_condition_word,
  output logic [15:0] output_frequency_word,
  // Setup
  input wire logic setup_write,
  input wire logic [1:0] protocol_select,
  input wire logic [7:0] station_address,
  output logic [1:0] active_protocol,
  output logic [7:0] active_address,
  output logic address_rejected,
  // Results to the drive
  output logic serial_control_enabled,
  output logic [15:0] speed_demand,
  output logic reverse_request,
  output logic overcurrent_trip
);

  top_state_t s;
  top_state_t next_s;
  div_if div ();

  logic serial_ok;
  logic over_current;
  logic trip_any;
  logic [15:0] ref_mag;
  logic [31:0] ref_product;
  logic [17:0] ref_scaled;
  logic [15:0] span;
  logic [15:0] freq_over_low;
  logic addr_ok;
  logic [15:0] quo_clamped;

  serial_divider freq_div (
    .clk(clk),
    .reset_n(reset_n),
    .div(div.engine)
  );

  // Frequency above low limit over the limit span gives the 16384 scale
  assign span = freq_high_limit - freq_low_limit;
  assign freq_over_low = (output_frequency > freq_low_limit) ? output_frequency - freq_low_limit : 16'h0000;
  assign div.dividend = {2'b00, freq_over_low, 14'h0000}; // RL18
  assign div.divisor = span;
  assign div.start = s.div_start;

  // Local operation blocks serial setpoint writes
  assign serial_ok = ~(keypad_stop | hand_mode); // RL9
  assign over_current = output_current > output_current_ceiling; // RL13
  assign trip_any = tripped | s.oc_trip;

  // Magnitude of the signed setpoint, direction kept apart
  assign ref_mag = speed_setpoint_word[15] ? 16'h0000 - speed_setpoint_word : speed_setpoint_word; // RL17
  assign ref_product = {16'h0000, ref_mag} * {16'h0000, ref_max - ref_min}; // RL15
  assign ref_scaled = ref_product[31:14] + {2'b00, ref_min}; // RL15

  // Address window depends on protocol
  always_comb begin
    case (protocol_select)
      `PROTO_NATIVE: addr_ok = station_address >= `ADDR_NATIVE_MIN && station_address <= `ADDR_NATIVE_MAX; // RL21
      `PROTO_AUTOMATION_A: addr_ok = station_address >= `ADDR_A_MIN && station_address <= `ADDR_A_MAX; // RL21
      `PROTO_AUTOMATION_B: addr_ok = station_address >= `ADDR_B_MIN && station_address <= `ADDR_B_MAX;
      `PROTO_MODBUS: addr_ok = station_address >= `ADDR_MODBUS_MIN && station_address <= `ADDR_MODBUS_MAX;
      default: addr_ok = 1'b0;
    endcase
  end

  // Quotient saturates at the signed ceiling; a zero span lands here too
  assign quo_clamped = (div.quotient > {16'h0000, `WORD_MAX}) ? `WORD_MAX : div.quotient[15:0]; // RL19

  always_comb begin
    next_s = s;
    // Coast pin: three flops, change taken once stages two and three agree
    next_s.coast_sync = {s.coast_sync[1:0], coast_terminal_pin};
    if (s.coast_sync[1] == s.coast_sync[2]) begin
      next_s.coast_level = s.coast_sync[2];
    end

    // Whole word built at once so the master never sees a half-updated mix
    next_s.status = 16'h0000; // RL5
    next_s.status[`BIT_CONTROL_READY] = drive_ready & ~trip_any; // RL1
    next_s.status[`BIT_DRIVE_READY] = drive_ready & ~trip_any & (~s.coast_level | serial_coast_cmd); // RL2
    next_s.status[`BIT_STANDBY] = drive_ready & ~trip_any & s.coast_level & ~serial_coast_cmd & ~start_cmd; // RL3
    next_s.status[`BIT_TRIPPED] = trip_any; // RL4
    next_s.status[`BIT_TRIP_LOCK] = trip_lock; // RL6
    next_s.status[`BIT_WARNING] = warning_any; // RL7
    next_s.status[`BIT_AT_REFERENCE] = motor_speed == s.speed_demand; // RL8
    next_s.status[`BIT_SERIAL_CONTROL] = serial_ok; // RL9
    next_s.status[`BIT_IN_RANGE] = output_frequency > freq_low_limit && output_frequency < freq_high_limit; // RL10
    next_s.status[`BIT_RUNNING] = start_cmd | (output_frequency != 16'h0000); // RL11
    next_s.status[`BIT_VOLTAGE] = dc_link_low | dc_link_high; // RL12
    next_s.status[`BIT_CURRENT] = over_current; // RL13
    next_s.status[`BIT_THERMAL] = motor_hot | drive_hot | thermistor_hot; // RL14

    // Setpoint taken only on a write under serial control; local mode keeps the old demand
    if (setpoint_write && serial_ok) begin // RL9
      next_s.reverse = speed_setpoint_word[15]; // RL16
      next_s.speed_demand = (ref_scaled > 18'h0ffff) ? 16'hffff : ref_scaled[15:0]; // RL15
    end

    // Overcurrent persistence counter; trip held until cleared
    if (over_current) begin
      if (s.oc_count >= overcurrent_delay_cycles) begin
        next_s.oc_trip = 1'b1; // RL13
      end else begin
        next_s.oc_count = s.oc_count + 24'h000001;
      end
    end else begin
      next_s.oc_count = 24'h000000;
    end
    if (trip_clear && !(over_current && s.oc_count >= overcurrent_delay_cycles)) begin
      next_s.oc_trip = 1'b0;
    end

    // Setup: bad address leaves the old setting and flags it
    if (setup_write) begin
      next_s.address_error = ~addr_ok;
      if (addr_ok) begin
        next_s.protocol = protocol_select; // RL20
        next_s.address = station_address; // RL21
      end
    end

    // Divider runs back to back; finished quotient becomes the frequency word
    next_s.div_start = ~div.busy & ~s.div_start;
    if (div.done) begin
      next_s.freq_word = output_reversed ? 16'h0000 - quo_clamped : quo_clamped; // RL19
    end
  end

  // Single edge captures every flag of the word together
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
      s.protocol <= `RESET_PROTOCOL; // RL20
      s.address <= `RESET_ADDRESS; // RL21
      s.speed_demand <= `RESET_WORD;
    end else begin
      s <= next_s; // RL22
    end
  end

  assign drive_condition_word = s.status;
  assign output_frequency_word = s.freq_word;
  assign active_protocol = s.protocol;
  assign active_address = s.address;
  assign address_rejected = s.address_error;
  assign serial_control_enabled = serial_ok;
  assign speed_demand = s.speed_demand;
  assign reverse_request = s.reverse;
  assign overcurrent_trip = s.oc_trip;

endmodule // drive_status_words

// file: bench/drive_status_words_asserts.sv
// Port checks for the drive condition word block.
// Assumes it is bound onto drive_status_words with one clock.
`timescale 1ns/10ps
module drive_status_words_asserts (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic tripped,
  input wire logic trip_lock,
  input wire logic warning_any,
  input wire logic keypad_stop,
  input wire logic hand_mode,
  input wire logic dc_link_low,
  input wire logic dc_link_high,
  input wire logic drive_hot,
  input wire logic start_cmd,
  input wire logic [15:0] output_frequency,
  input wire logic [15:0] freq_low_limit,
  input wire logic [15:0] output_current,
  input wire logic [15:0] output_current_ceiling,
  input wire logic [23:0] overcurrent_delay_cycles,
  input wire logic setpoint_write,
  input wire logic [15:0] speed_setpoint_word,
  input wire logic [15:0] drive_condition_word,
  input wire logic serial_control_enabled,
  input wire logic reverse_request,
  input wire logic overcurrent_trip
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Six cycles over the ceiling with the bench delay of five
  sequence over_long;
    (output_current > output_current_ceiling && overcurrent_delay_cycles == 24'h5)[*6];
  endsequence
  sequence write_taken;
    setpoint_write && serial_control_enabled;
  endsequence
  ready_clear_a: assert property (tripped |=> !drive_condition_word[0])
    else $error("ready bit set while tripped");
  unused_zero_a: assert property (drive_condition_word[5:4] == 2'h0 && !drive_condition_word[12])
    else $error("unused status bit set");
  lock_bit_a: assert property (1 |=> drive_condition_word[6] == $past(trip_lock))
    else $error("lock bit wrong");
  warn_bit_a: assert property (1 |=> drive_condition_word[7] == $past(warning_any))
    else $error("warning bit wrong");
  local_gate_a: assert property (serial_control_enabled == !(keypad_stop || hand_mode))
    else $error("serial gate wrong");
  range_low_a: assert property (output_frequency <= freq_low_limit |=> !drive_condition_word[10])
    else $error("range bit set at low limit");
  run_bit_a: assert property ((start_cmd || output_frequency != 16'h0) |=> drive_condition_word[11])
    else $error("running bit clear");
  volt_bit_a: assert property ((dc_link_low || dc_link_high) |=> drive_condition_word[13])
    else $error("voltage bit clear");
  over_trip_a: assert property (over_long |-> ##[0:2] overcurrent_trip)
    else $error("overcurrent trip late");
  heat_bit_a: assert property (drive_hot |=> drive_condition_word[15])
    else $error("thermal bit clear");
  ref_sign_a: assert property (write_taken |=> reverse_request == $past(speed_setpoint_word[15]))
    else $error("direction not taken from sign");
endmodule // drive_status_words_asserts

bind drive_status_words drive_status_words_asserts drive_status_words_asserts_i (.*);

// file: bench/bus_master_model.sv
// Serial master model: sends speed references and station setup.
// Assumes clk is the block clock; drives 1 ns after each edge.
`timescale 1ns/10ps
module bus_master_model (
  input wire logic clk,
  output logic setpoint_write,
  output logic [15:0] speed_setpoint_word,
  output logic setup_write,
  output logic [1:0] protocol_select,
  output logic [7:0] station_address
);
  initial begin
    setpoint_write = 1'b0;
    speed_setpoint_word = 16'h0000;
    setup_write = 1'b0;
    protocol_select = 2'h0;
    station_address = 8'h01;
  end
  // Signed 16-bit reference, 4000h full span; word kept after pulse
  task automatic send_ref(input logic [15:0] w);
    @(posedge clk);
    #1 setpoint_write = 1'b1;
    speed_setpoint_word = w;
    @(posedge clk);
    #1 setpoint_write = 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // Setup pulse, returns once the answer has landed
  task automatic setup(input logic [1:0] p, input logic [7:0] a);
    @(posedge clk);
    #1 setup_write = 1'b1;
    protocol_select = p;
    station_address = a;
    @(posedge clk);
    #1 setup_write = 1'b0;
    @(posedge clk);
    #1;
  endtask
endmodule // bus_master_model

// file: bench/drive_status_words_bench.sv
// Bench for the drive status block: word bits, scaling and setup.
// Assumes the master model owns the serial inputs.
`timescale 1ns/10ps
module drive_status_words_bench;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic tripped, trip_lock, trip_clear, drive_ready, coast_terminal_pin, serial_coast_cmd, start_cmd;
  logic warning_any, keypad_stop, hand_mode, dc_link_low, dc_link_high, motor_hot, drive_hot, thermistor_hot;
  logic output_reversed, setpoint_write, setup_write, address_rejected, serial_control_enabled;
  logic reverse_request, overcurrent_trip;
  logic [15:0] output_current, output_current_ceiling, motor_speed, output_frequency, freq_low_limit;
  logic [15:0] freq_high_limit, ref_min, ref_max, speed_setpoint_word, drive_condition_word;
  logic [15:0] output_frequency_word, speed_demand;
  logic [23:0] overcurrent_delay_cycles;
  logic [1:0] protocol_select, active_protocol;
  logic [7:0] station_address, active_address;
  int num_errors = 0;
  int compares = 0;
  always #10 clk = ~clk;
  drive_status_words drive_status_words_i (.*);
  bus_master_model bus_master_model_i (.*);
  task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic print_verdict;
    if (num_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  // Five cycles covers the three-flop coast path
  task automatic word_is(input logic [15:0] e);
    repeat (5) @(posedge clk);
    #1 check("word", drive_condition_word, e);
  endtask
  task automatic fault_case;
    tick;
    {tripped, trip_lock, warning_any, dc_link_high, motor_hot, keypad_stop, start_cmd} = 7'h7f;
    word_is(16'ha9c8);
    check("gate", {15'h0, serial_control_enabled}, 16'h0);
    {tripped, trip_lock, warning_any, dc_link_high, motor_hot, keypad_stop, start_cmd} = 7'h00;
    word_is(16'h0305);
  endtask
  task automatic coast_case;
    {coast_terminal_pin, dc_link_low, thermistor_hot, hand_mode} = 4'h7;
    word_is(16'ha103);
    {coast_terminal_pin, dc_link_low, thermistor_hot, hand_mode, serial_coast_cmd, drive_hot} = 6'h23;
    word_is(16'h8303);
    {serial_coast_cmd, drive_hot} = 2'h0;
  endtask
  // Divider result takes about 34 cycles, so wait 80, over twice that
  task automatic freq_case;
    output_frequency = 16'h0019;
    repeat (80) @(posedge clk);
    #1 check("freq", output_frequency_word, 16'h2000);
    check("word", drive_condition_word, 16'h0f05);
    output_reversed = 1'b1;
    repeat (80) @(posedge clk);
    #1 check("freq", output_frequency_word, 16'he000);
    {output_reversed, output_frequency} = 17'h00064;
    repeat (80) @(posedge clk);
    #1 check("freq", output_frequency_word, 16'h7fff);
    check("word", drive_condition_word, 16'h0b05);
    output_frequency = 16'h0000;
  endtask
  task automatic setpoint_case;
    bus_master_model_i.send_ref(16'he000);
    check("dir", {15'h0, reverse_request}, 16'h1);
    check("demand", speed_demand, 16'h0258);
    check("at_ref", drive_condition_word & 16'h0100, 16'h0000);
    bus_master_model_i.send_ref(16'h7fff);
    check("dir", {15'h0, reverse_request}, 16'h0);
    check("demand", speed_demand, 16'h0833);
    hand_mode = 1'b1;
    bus_master_model_i.send_ref(16'hf000);
    check("dir", {15'h0, reverse_request}, 16'h0);
    check("demand", speed_demand, 16'h0833);
    hand_mode = 1'b0;
    motor_speed = 16'h0833;
    word_is(16'h0305);
  endtask
  task automatic overcurrent_case;
    output_current = 16'h00c8;
    repeat (10) tick;
    check("trip", drive_condition_word & 16'h4009, 16'h4008);
    output_current = 16'h0000;
    trip_clear = 1'b1;
    tick;
    trip_clear = 1'b0;
    word_is(16'h0305);
  endtask
  // Codes with in-range and out-of-range addresses
  task automatic setup_case;
    logic [1:0] p [7] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h3, 2'h3};
    logic [7:0] a [7] = '{8'h7e, 8'h7f, 8'h00, 8'hff, 8'h62, 8'hf8, 8'h01};
    logic ok [7] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
    logic [9:0] exp_set = 10'h001;
    for (int i = 0; i < 7; i++) begin
      bus_master_model_i.setup(p[i], a[i]);
      if (ok[i]) exp_set = {p[i], a[i]};
      check("reject", {15'h0, address_rejected}, {15'h0, !ok[i]});
      check("setup", {6'h0, active_protocol, active_address}, {6'h0, exp_set});
    end
  endtask
  initial begin
    {tripped, trip_lock, trip_clear, serial_coast_cmd, start_cmd, warning_any, keypad_stop} = 7'h00;
    {hand_mode, dc_link_low, dc_link_high, motor_hot, drive_hot, thermistor_hot, output_reversed} = 7'h00;
    {drive_ready, coast_terminal_pin} = 2'h3;
    {output_current, motor_speed, output_frequency, freq_low_limit} = 64'h0;
    output_current_ceiling = 16'h0064;
    overcurrent_delay_cycles = 24'h000005;
    freq_high_limit = 16'h0032;
    ref_min = 16'h0064;
    ref_max = 16'h044c;
    repeat (12) @(posedge clk);
    #1 check("setup", {6'h0, active_protocol, active_address}, 16'h0001);
    reset_n = 1'b1;
    word_is(16'h0305);
    fault_case;
    coast_case;
    freq_case;
    setpoint_case;
    overcurrent_case;
    setup_case;
    print_verdict;
  end
  // Whole run is near 330 cycles
  initial begin
    #100000;
    num_errors++;
    print_verdict;
  end
endmodule // drive_status_words_bench
